// file: logic/csd_cfg.svh
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CSD_BANKS      8
`define CSD_STRIDE     8'h0c
`define CSD_OFS_START  8'h00
`define CSD_OFS_MASK   8'h04
`define CSD_OFS_CTRL   8'h08
`define CSD_MASK_WMASK 32'hffff0101
`define CSD_CTRL_WMASK 16'hfdff
`define CSD_CTRL_RST   16'h0000
`define CSD_BOOT_CTRL  16'h3d00

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CSD_BAM   31:16
`define CSD_WP    8
`define CSD_V     0
`define CSD_LATER_READ_WAITS  15:14
`define CSD_IWS   13:10
`define CSD_AA    8
`define CSD_PS    7:6
`define CSD_BEM   5
`define CSD_READ_BURST_ENABLE  4
`define CSD_WRITE_BURST_ENABLE  3
`define CSD_LATER_WRITE_WAITS  2:0

// ----------------------------------------------------------------
// port width codes and strap codes
// ----------------------------------------------------------------
`define CSD_PS_32   2'b00
`define CSD_PS_8    2'b01
`define CSD_PS_16   2'b10
`define CSD_STRAP_16 2'b01
`define CSD_STRAP_8  2'b10

`endif

// file: logic/csd_chip_select.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "csd_cfg.svh"

module csd_chip_select (
  input  wire logic                  clk,             // bus clock
  input  wire logic                  reset,           // async, high
  input  wire logic [7:0]            reg_addr,        // register address
  input  wire logic [31:0]           reg_wdata,       // write data
  input  wire logic                  reg_write,       // write strobe
  input  wire logic                  reg_read,        // read strobe
  output logic      [31:0]           reg_rdata,       // read data
  input  wire logic [1:0]            boot_width_pins, // strap pins
  input  wire logic                  acc_start,       // access request
  input  wire logic [31:0]           acc_addr,        // access address
  input  wire logic                  acc_write,       // 1 write, 0 read
  input  wire csd_pkg::csd_size_type acc_size,        // access size
  input  wire logic                  transfer_ack_n,  // external ack pin
  output logic                       acc_done,        // access finished
  output logic                       access_error,    // protect fault
  output logic      [7:0]            chip_select_n,   // selects, low
  output logic      [3:0]            byte_strobe_n,   // lanes 31..0, low
  output logic      [31:0]           ext_addr,        // external address
  output logic                       internal_ack,    // auto ack pulse
  output logic                       beat_ack,        // beat ended
  output logic                       burst_active,    // burst in flight
  output logic      [1:0]            port_width       // lane select code
);
  import csd_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [`CSD_BANKS-1:0]        hit;
  logic [`CSD_BANKS-1:0]        wp_vec;
  logic [`CSD_BANKS-1:0]        valid_vec;
  logic [`CSD_BANKS-1:0][15:0]  ctrl_vec;
  logic [`CSD_BANKS-1:0][31:0]  rd_part;
  logic [31:0]                  next_rdata;
  logic                         boot_released;
  logic                         strap_taken;
  logic [1:0]                   strap_ps;
  logic [2:0]                   ack_sync;
  logic                         ack_level;
  logic [2:0]                   sel;
  logic                         sel_hit;
  logic [15:0]                  sel_ctrl;
  logic [2:0]                   lsb;
  logic [2:0]                   lpb;
  logic [3:0]                   next_beats;
  logic [3:0]                   next_lanes;
  logic                         next_burst;
  logic [3:0]                   next_sec;
  csd_state_type                state;
  logic [2:0]                   cur_bank;
  logic [3:0]                   beats_left;
  logic [3:0]                   cnt;
  logic [3:0]                   wait_target;
  logic [3:0]                   first_wait;
  logic [3:0]                   sec_wait;
  logic [2:0]                   cur_step;
  logic [3:0]                   cur_lanes;
  logic                         cur_aa;
  logic                         cur_write;
  logic                         cur_bem;
  logic                         beat_end;

  // ----------------------------------------------------------------
  // per-bank registers and decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `CSD_BANKS; i++)
  begin : g_bank
    localparam logic [7:0] BASE = 8'(i) * `CSD_STRIDE;
    logic [15:0] start_q;
    logic [31:0] mask_q;
    logic [15:0] ctrl_q;

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        start_q <= 16'h0000;
        mask_q  <= 32'h00000000;
      end
      else if (reg_write)
      begin
        if (reg_addr == BASE + `CSD_OFS_START)
          start_q <= reg_wdata[15:0];
        // reserved bits are dropped, so a careless write is harmless
        if (reg_addr == BASE + `CSD_OFS_MASK)
          mask_q <= reg_wdata & `CSD_MASK_WMASK;
      end
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        ctrl_q <= (i == 0) ? `CSD_BOOT_CTRL : `CSD_CTRL_RST;
      else if (i == 0 && !strap_taken)
        ctrl_q[`CSD_PS] <= strap_ps;
      else if (reg_write && reg_addr == BASE + `CSD_OFS_CTRL)
        ctrl_q <= reg_wdata[15:0] & `CSD_CTRL_WMASK;
    end

    assign valid_vec[i] = mask_q[`CSD_V];
    assign wp_vec[i]    = mask_q[`CSD_WP];
    assign ctrl_vec[i]  = ctrl_q;
    // each mask one doubles the block above 64 KB
    assign hit[i] = (mask_q[`CSD_V]
                     && (((acc_addr[31:16] ^ start_q)
                          & ~mask_q[`CSD_BAM]) == 16'h0000))
                    || (i == 0 && !boot_released);
    assign rd_part[i] =
      (reg_addr == BASE + `CSD_OFS_START) ? {16'h0000, start_q} :
      (reg_addr == BASE + `CSD_OFS_MASK)  ? mask_q :
      (reg_addr == BASE + `CSD_OFS_CTRL)  ? {16'h0000, ctrl_q} :
      32'h00000000;
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h00000000;
    for (int k = 0; k < `CSD_BANKS; k++)
      next_rdata = next_rdata | rd_part[k];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= reg_read ? next_rdata : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // boot strap and global boot select
  // ----------------------------------------------------------------
  // the strap pins are assumed steady around reset, so they are taken
  // raw on the first edge after release
  always_comb
  begin
    case (boot_width_pins)
      `CSD_STRAP_16: strap_ps = `CSD_PS_16;
      `CSD_STRAP_8:  strap_ps = `CSD_PS_8;
      default:       strap_ps = `CSD_PS_32;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      strap_taken <= 1'b0;
    else
      strap_taken <= 1'b1;
  end

  // once released the global select only comes back through reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      boot_released <= 1'b0;
    else if (valid_vec[0])
      boot_released <= 1'b1;
  end

  // ----------------------------------------------------------------
  // external acknowledge synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_sync  <= 3'b000;
      ack_level <= 1'b0;
    end
    else
    begin
      ack_sync <= {ack_sync[1:0], ~transfer_ack_n};
      if (ack_sync[2] == ack_sync[1])
        ack_level <= ack_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // access planning
  // ----------------------------------------------------------------
  always_comb
  begin
    sel     = 3'h0;
    sel_hit = 1'b0;
    for (int k = `CSD_BANKS - 1; k >= 0; k--)
      if (hit[k])
      begin
        sel     = 3'(k);
        sel_hit = 1'b1;
      end
  end

  assign sel_ctrl = ctrl_vec[sel];

  always_comb
  begin
    lsb = (acc_size == CSD_LINE) ? 3'h4 : {1'b0, acc_size};
    case (sel_ctrl[`CSD_PS])
      `CSD_PS_32: lpb = 3'h2;
      `CSD_PS_8:  lpb = 3'h0;
      default:    lpb = 3'h1;
    endcase
    next_beats = (lsb > lpb) ? 4'((5'h01 << (lsb - lpb)) - 5'h01) : 4'h0;
    if (lsb >= lpb)
      next_lanes = (lpb == 3'h2) ? 4'hf : (lpb == 3'h1) ? 4'hc : 4'h8;
    else if (lpb == 3'h2)
      next_lanes = (lsb == 3'h0) ? (4'h8 >> acc_addr[1:0])
                 : (acc_addr[1] ? 4'h3 : 4'hc);
    else
      next_lanes = acc_addr[0] ? 4'h4 : 4'h8;
    next_burst = (next_beats != 4'h0)
                 && (acc_write ? sel_ctrl[`CSD_WRITE_BURST_ENABLE]
                               : sel_ctrl[`CSD_READ_BURST_ENABLE]);
    if (acc_write)
      next_sec = (sel_ctrl[`CSD_LATER_WRITE_WAITS] != 3'h0 && sel_ctrl[`CSD_AA])
               ? {1'b0, sel_ctrl[`CSD_LATER_WRITE_WAITS]} - 4'h1
               : sel_ctrl[`CSD_IWS];
    else
      next_sec = (sel_ctrl[`CSD_LATER_READ_WAITS] != 2'h0 && sel_ctrl[`CSD_AA])
               ? {2'h0, sel_ctrl[`CSD_LATER_READ_WAITS]} - 4'h1
               : sel_ctrl[`CSD_IWS];
  end

  // external ack is checked first so it always ends the beat itself
  assign beat_end = ack_level
                    || (cur_aa && cnt == wait_target);

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state         <= CSD_IDLE;
      chip_select_n <= 8'hff;
      byte_strobe_n <= 4'hf;
      ext_addr      <= 32'h00000000;
      acc_done      <= 1'b0;
      access_error  <= 1'b0;
      internal_ack  <= 1'b0;
      beat_ack      <= 1'b0;
      burst_active  <= 1'b0;
      port_width    <= `CSD_PS_32;
      cur_bank      <= 3'h0;
      beats_left    <= 4'h0;
      cnt           <= 4'h0;
      wait_target   <= 4'h0;
      first_wait    <= 4'h0;
      sec_wait      <= 4'h0;
      cur_step      <= 3'h1;
      cur_lanes     <= 4'h0;
      cur_aa        <= 1'b0;
      cur_write     <= 1'b0;
      cur_bem       <= 1'b0;
    end
    else
    begin
      acc_done     <= 1'b0;
      access_error <= 1'b0;
      internal_ack <= 1'b0;
      beat_ack     <= 1'b0;
      case (state)
        CSD_IDLE:
        begin
          if (acc_start && !sel_hit)
            acc_done <= 1'b1;
          else if (acc_start && acc_write && wp_vec[sel])
          begin
            access_error <= 1'b1;
            acc_done     <= 1'b1;
          end
          else if (acc_start)
          begin
            state         <= CSD_BEAT;
            chip_select_n <= ~(8'h01 << sel);
            byte_strobe_n <= ~(next_lanes
                               & {4{acc_write
                                    || sel_ctrl[`CSD_BEM]}});
            ext_addr      <= acc_addr;
            burst_active  <= next_burst;
            port_width    <= sel_ctrl[`CSD_PS];
            cur_bank      <= sel;
            beats_left    <= next_beats;
            cnt           <= 4'h0;
            wait_target   <= sel_ctrl[`CSD_IWS];
            first_wait    <= sel_ctrl[`CSD_IWS];
            sec_wait      <= next_sec;
            cur_step      <= 3'(3'h1 << lpb);
            cur_lanes     <= next_lanes;
            cur_aa        <= sel_ctrl[`CSD_AA];
            cur_write     <= acc_write;
            cur_bem       <= sel_ctrl[`CSD_BEM];
          end
        end
        CSD_BEAT:
        begin
          if (beat_end)
          begin
            beat_ack     <= 1'b1;
            internal_ack <= !ack_level;
            cnt          <= 4'h0;
            if (beats_left == 4'h0)
            begin
              state         <= CSD_IDLE;
              chip_select_n <= 8'hff;
              byte_strobe_n <= 4'hf;
              burst_active  <= 1'b0;
              acc_done      <= 1'b1;
            end
            else
            begin
              beats_left <= beats_left - 4'h1;
              ext_addr   <= ext_addr + {29'h0, cur_step};
              if (burst_active)
                wait_target <= sec_wait;
              else
              begin
                // split transfers drop the select for one cycle
                wait_target   <= first_wait;
                state         <= CSD_GAP;
                chip_select_n <= 8'hff;
                byte_strobe_n <= 4'hf;
              end
            end
          end
          else
            cnt <= cnt + 4'h1;
        end
        CSD_GAP:
        begin
          state         <= CSD_BEAT;
          chip_select_n <= ~(8'h01 << cur_bank);
          byte_strobe_n <= ~(cur_lanes & {4{cur_write || cur_bem}});
        end
        default:
          state <= CSD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_PROTECT: assert property (@(posedge clk) disable iff (reset)
    state == CSD_IDLE && acc_start && sel_hit && acc_write && wp_vec[sel]
    |=> access_error && chip_select_n == 8'hff && state == CSD_IDLE)
    else $error("protected write was not refused");
  AST_VALID: assert property (@(posedge clk) disable iff (reset)
    (~chip_select_n & ~valid_vec & 8'hfe) == 8'h00)
    else $error("select asserted for an invalid bank");
  AST_RESET_CLEAR: assert property (@(posedge clk)
    $fell(reset) |-> valid_vec == 8'h00 && !boot_released)
    else $error("valid bits not cleared by reset");
  AST_INT_ACK: assert property (@(posedge clk) disable iff (reset)
    internal_ack |-> $past(cur_aa) && $past(cnt) == $past(wait_target))
    else $error("internal ack at the wrong count");
  AST_NO_AA: assert property (@(posedge clk) disable iff (reset)
    state == CSD_BEAT && !cur_aa |=> !internal_ack)
    else $error("internal ack with auto-ack off");
  AST_EXT_WINS: assert property (@(posedge clk) disable iff (reset)
    state == CSD_BEAT && ack_level |=> beat_ack && !internal_ack)
    else $error("external ack did not take precedence");
  AST_BURST_ADDR: assert property (@(posedge clk) disable iff (reset)
    state == CSD_BEAT && beat_end && burst_active && beats_left != 4'h0
    |=> ext_addr == $past(ext_addr) + {29'h0, cur_step}
        && chip_select_n == $past(chip_select_n))
    else $error("burst address did not advance");
  AST_SPLIT_GAP: assert property (@(posedge clk) disable iff (reset)
    state == CSD_BEAT && beat_end && !burst_active && beats_left != 4'h0
    |=> chip_select_n == 8'hff ##1 chip_select_n != 8'hff)
    else $error("split beat without a select gap");
  AST_BOOT: assert property (@(posedge clk) disable iff (reset)
    state == CSD_IDLE && acc_start && !boot_released && !acc_write
    |=> !chip_select_n[0])
    else $error("boot select not global");
  AST_STROBE: assert property (@(posedge clk) disable iff (reset)
    state == CSD_BEAT && !cur_write && !cur_bem |-> byte_strobe_n == 4'hf)
    else $error("strobe asserted on a read");

  COV_BURST: cover property (@(posedge clk) disable iff (reset)
    beat_ack && burst_active && !cur_write);
  COV_ERROR: cover property (@(posedge clk) disable iff (reset)
    access_error);
  COV_EXT: cover property (@(posedge clk) disable iff (reset)
    beat_ack && !internal_ack);
  COV_SPLIT: cover property (@(posedge clk) disable iff (reset)
    state == CSD_GAP);

endmodule : csd_chip_select

// file: logic/csd_pkg.sv
package csd_pkg;

  typedef enum logic [1:0] {
    CSD_BYTE,
    CSD_WORD,
    CSD_LONG,
    CSD_LINE
  } csd_size_type;

  typedef enum logic [1:0] {
    CSD_IDLE,
    CSD_BEAT,
    CSD_GAP
  } csd_state_type;

endpackage : csd_pkg

// file: verif/csd_ext_mem.sv
`timescale 1ns/1ps

module csd_ext_mem (
  input  wire logic        clk,           // bus clock
  input  wire logic [7:0]  chip_select_n, // selects, low
  input  wire logic [31:0] ext_addr,      // beat address
  input  wire logic        ack_en,        // answer with external ack
  input  wire logic [3:0]  ack_delay,     // cycles before ack
  output logic             transfer_ack_n // ack pin, low
);
  // ack is held two cycles so the three-flop sync surely sees it;
  // once released the pin returns to its pull-up level
  logic [31:0] last_addr;

  initial transfer_ack_n = 1'b1;

  always
  begin
    @(posedge clk);
    if (ack_en && chip_select_n != 8'hff)
    begin
      last_addr = ext_addr;
      repeat (ack_delay) @(posedge clk);
      transfer_ack_n <= 1'b0;
      repeat (2) @(posedge clk);
      transfer_ack_n <= 1'b1;
      // one ack per beat: wait for the beat to move on
      for (int i = 0; i < 40; i++)
      begin
        @(posedge clk);
        if (chip_select_n == 8'hff || ext_addr != last_addr)
          break;
      end
    end
  end
endmodule : csd_ext_mem

// file: verif/tb.sv
`timescale 1ns/1ps

module tb;
  import csd_pkg::*;

  logic         clk;
  logic         reset;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_write;
  logic         reg_read;
  logic [31:0]  reg_rdata;
  logic [1:0]   boot_width_pins;
  logic         acc_start;
  logic [31:0]  acc_addr;
  logic         acc_write;
  csd_size_type acc_size;
  logic         transfer_ack_n;
  logic         acc_done;
  logic         access_error;
  logic [7:0]   chip_select_n;
  logic [3:0]   byte_strobe_n;
  logic [31:0]  ext_addr;
  logic         internal_ack;
  logic         beat_ack;
  logic         burst_active;
  logic [1:0]   port_width;
  logic         ack_en;
  logic [7:0]   cs_val;
  logic [1:0]   pw_val;
  logic [3:0]   bs_and;
  logic [31:0]  addr2;
  logic         err_seen;
  logic         burst_seen;
  logic         gap_seen;
  int           beats;
  int           len1;
  int           len2;
  int           niack;
  int           err_total;
  int           total_checks;

  csd_chip_select i_csd_chip_select (
    .clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .boot_width_pins(boot_width_pins),
    .acc_start(acc_start), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_size(acc_size), .transfer_ack_n(transfer_ack_n),
    .acc_done(acc_done), .access_error(access_error),
    .chip_select_n(chip_select_n), .byte_strobe_n(byte_strobe_n),
    .ext_addr(ext_addr), .internal_ack(internal_ack),
    .beat_ack(beat_ack), .burst_active(burst_active),
    .port_width(port_width)
  );

  csd_ext_mem i_csd_ext_mem (
    .clk(clk), .chip_select_n(chip_select_n), .ext_addr(ext_addr),
    .ack_en(ack_en), .ack_delay(4'h3), .transfer_ack_n(transfer_ack_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
  begin
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  end
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
  begin
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  end
  endtask : rd_chk

  // one access; gathers selects, beat lengths and flags per cycle
  task automatic acc(input logic [31:0] a, input logic w,
                     input csd_size_type s);
    int   t;
    int   t_beg;
    logic in_gap;
  begin
    @(posedge clk);
    acc_start <= 1'b1;
    acc_addr <= a;
    acc_write <= w;
    acc_size <= s;
    beats = 0;
    len1 = 0;
    len2 = 0;
    niack = 0;
    t_beg = 0;
    in_gap = 1'b1;
    cs_val = 8'hff;
    pw_val = 2'b00;
    bs_and = 4'hf;
    err_seen = 1'b0;
    burst_seen = 1'b0;
    gap_seen = 1'b0;
    for (t = 0; t < 200; t++)
    begin
      @(posedge clk);
      acc_start <= 1'b0;
      #1;
      if (chip_select_n !== 8'hff)
      begin
        bs_and = bs_and & byte_strobe_n;
        if (in_gap && beats == 0)
        begin
          cs_val = chip_select_n;
          pw_val = port_width;
        end
        if (in_gap)
          t_beg = t;
        in_gap = 1'b0;
      end
      else if ((beats > 0 || beat_ack === 1'b1) && acc_done !== 1'b1)
      begin
        gap_seen = 1'b1;
        in_gap = 1'b1;
      end
      if (access_error === 1'b1)
        err_seen = 1'b1;
      if (burst_active === 1'b1)
        burst_seen = 1'b1;
      if (internal_ack === 1'b1)
        niack++;
      if (beat_ack === 1'b1)
      begin
        beats++;
        if (beats == 1)
          len1 = t - t_beg;
        if (beats == 1)
          addr2 = ext_addr;
        if (beats == 2)
          len2 = t - t_beg;
        t_beg = t;
      end
      if (acc_done === 1'b1)
        break;
    end
    if (t == 200)
    begin
      err_total++;
      test_done();
    end
  end
  endtask : acc

  // long access through bank 1 with control value c
  task automatic row(input logic [15:0] c, input logic w, input int nb,
                     input int l1, input int l2, input logic bu,
                     input logic ga, input logic [3:0] bs);
  begin
    wr(8'h14, {16'h0000, c});
    acc(32'h00400000, w, CSD_LONG);
    chk(beats, nb);
    chk(len1, l1);
    if (nb > 1)
      chk(len2, l2);
    chk(32'(burst_seen), 32'(bu));
    chk(32'(gap_seen), 32'(ga));
    chk(32'(bs_and), 32'(bs));
    chk(32'(pw_val), 32'(c[7:6]));
  end
  endtask : row

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    boot_width_pins = 2'b10;
    acc_start = 1'b0;
    acc_addr = 32'h0;
    acc_write = 1'b0;
    acc_size = CSD_BYTE;
    ack_en = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'h3d40);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h60, 32'h0);
    acc(32'h12345678, 1'b0, CSD_BYTE);
    chk(32'(cs_val), 32'hfe);
    chk(32'(pw_val), 32'h1);
    chk(len1, 16);
    chk(niack, 1);
    wr(8'h10, 32'hffffffff);
    rd_chk(8'h10, 32'hffff0101);
    wr(8'h14, 32'hffffffff);
    rd_chk(8'h14, 32'h0000fdff);
    wr(8'h0c, 32'h00000040);
    wr(8'h10, 32'h001f0000);
    wr(8'h14, 32'h00000100);
    wr(8'h00, 32'h00000080);
    wr(8'h04, 32'h00000001);
    acc(32'h00400000, 1'b0, CSD_BYTE);
    chk(32'(cs_val), 32'hff);
    wr(8'h10, 32'h001f0001);
    acc(32'h005ffffc, 1'b0, CSD_BYTE);
    chk(32'(cs_val), 32'hfd);
    acc(32'h00600000, 1'b0, CSD_BYTE);
    chk(32'(cs_val), 32'hff);
    acc(32'h00800000, 1'b0, CSD_BYTE);
    chk(32'(cs_val), 32'hfe);
    wr(8'h18, 32'h00000020);
    wr(8'h1c, 32'h00000101);
    wr(8'h20, 32'h00000100);
    acc(32'h00200000, 1'b1, CSD_LONG);
    chk(32'(err_seen), 32'h1);
    chk(32'(cs_val), 32'hff);
    acc(32'h00200000, 1'b0, CSD_LONG);
    chk(32'(cs_val), 32'hfb);
    chk(32'(err_seen), 32'h0);
    row(16'h4590, 1'b0, 2, 2, 1, 1'b1, 1'b0, 4'hf);
    chk(addr2, 32'h00400002);
    row(16'h0590, 1'b0, 2, 2, 2, 1'b1, 1'b0, 4'hf);
    row(16'hc590, 1'b0, 2, 2, 3, 1'b1, 1'b0, 4'hf);
    row(16'h45b0, 1'b0, 2, 2, 1, 1'b1, 1'b0, 4'h3);
    row(16'h0580, 1'b0, 2, 2, 2, 1'b0, 1'b1, 4'hf);
    row(16'h0588, 1'b1, 2, 2, 2, 1'b1, 1'b0, 4'h3);
    row(16'h4580, 1'b1, 2, 2, 2, 1'b0, 1'b1, 4'h3);
    row(16'h0550, 1'b0, 4, 2, 2, 1'b1, 1'b0, 4'hf);
    row(16'h0110, 1'b0, 1, 1, 0, 1'b0, 1'b0, 4'hf);
    acc(32'h00400000, 1'b0, CSD_LINE);
    chk(beats, 4);
    chk(32'(burst_seen), 32'h1);
    chk(addr2, 32'h00400004);
    wr(8'h14, 32'h00000540);
    acc(32'h00400000, 1'b0, CSD_WORD);
    chk(beats, 2);
    chk(32'(gap_seen), 32'h1);
    chk(len2, 2);
    wr(8'h14, 32'h00000100);
    acc(32'h00400001, 1'b1, CSD_BYTE);
    chk(32'(bs_and), 32'hb);
    // ----------------------------------------------------------------
    // external acknowledge from the far side
    // ----------------------------------------------------------------
    ack_en <= 1'b1;
    wr(8'h14, 32'h00000000);
    acc(32'h00400000, 1'b0, CSD_BYTE);
    chk(niack, 0);
    chk(32'(len1 > 2), 32'h1);
    wr(8'h14, 32'h00003d00);
    acc(32'h00400000, 1'b0, CSD_BYTE);
    chk(niack, 0);
    chk(32'(len1 < 16), 32'h1);
    ack_en <= 1'b0;
    test_done();
  end
endmodule : tb
